//--- tb/ips_cpu_model.sv
// Purpose: CPU core stand-in taking and ending service
// Assumes: Request stands until acknowledged
// Notes:   Fixed service time, ack delay from bench
`timescale 1ns/1ns
module ips_cpu_model #(
    parameter int SVC = 40
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_req,
    input  wire logic [1:0] i_delay,
    output logic            o_ack,
    output logic            o_done
);
    int wait_cnt;
    int svc_cnt;
    int depth;
    always @(posedge i_clk) begin
        o_ack  <= 1'h0;
        o_done <= 1'h0;
        if (!i_rst_n) begin
            wait_cnt <= 0;
            svc_cnt  <= 0;
            depth    <= 0;
        end else begin
            svc_cnt <= svc_cnt + 1;
            // No second ack while the first is still on the wire
            if (i_req && !o_ack) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= i_delay) begin
                    o_ack    <= 1'h1;
                    wait_cnt <= 0;
                    svc_cnt  <= 0;
                    depth    <= depth + 1;
                end
            end else if (depth > 0 && svc_cnt >= SVC) begin
                o_done  <= 1'h1;
                svc_cnt <= 0;
                depth   <= depth - 1;
            end
        end
    end
endmodule : ips_cpu_model

//--- tb/ips_props.sv
// Purpose: Port checker for ips_top
// Assumes: One clock, sync reset
// Notes:   Keeps its own copy of in-service levels
`timescale 1ns/1ns
module ips_props #(
    parameter int ADDR_W = 8
) (
    input wire logic              I_CORE_CLK,
    input wire logic              I_RST_N,
    input wire logic              I_AWVALID,
    input wire logic              O_AWREADY,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic [31:0]       I_WDATA,
    input wire logic              I_ARVALID,
    input wire logic              O_ARREADY,
    input wire logic              O_RVALID,
    input wire logic              O_IRQ,
    input wire logic              O_CPU_REQ,
    input wire logic [2:0]        O_CPU_REQ_LVL,
    input wire logic              I_CPU_ACK,
    input wire logic              I_CPU_DONE
);
    logic [7:0] act;
    logic       nest;
    function automatic logic [2:0] top_lvl(input logic [7:0] a);
        top_lvl = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (a[i]) top_lvl = 3'(i);
        end
    endfunction : top_lvl
    ////////////////////////////////////////////////////////////////
    // Only valid while address and data arrive together
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            act  <= 8'h00;
            nest <= 1'h0;
        end else begin
            act <= (I_CPU_DONE ? act & ~(8'h01 << top_lvl(act)) : act)
                 | ((I_CPU_ACK && O_CPU_REQ) ? 8'h01 << O_CPU_REQ_LVL : 8'h00);
            if (I_AWVALID && O_AWREADY && (I_AWADDR >> 2) == 1) nest <= I_WDATA[15];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence ar_take_s;
        I_ARVALID && O_ARREADY;
    endsequence
    sequence r_give_s;
        O_RVALID && !O_ARREADY;
    endsequence
    rst_idle_a: assert property ($rose(I_RST_N) |-> O_AWREADY && !O_CPU_REQ && !O_IRQ)
        else $error("Outputs not idle after reset");
    rd_answer_a: assert property (ar_take_s |=> r_give_s)
        else $error("Read answer late");
    ack_drop_a: assert property (I_CPU_ACK && O_CPU_REQ |=> !O_CPU_REQ)
        else $error("Request stays after ack");
    req_irq_a: assert property (O_CPU_REQ |-> O_IRQ)
        else $error("Request without enabled flag");
    lvl_nonzero_a: assert property (O_CPU_REQ |-> O_CPU_REQ_LVL != 3'h0)
        else $error("Level zero requested");
    preempt_a: assert property ($rose(O_CPU_REQ) |-> O_CPU_REQ_LVL > top_lvl(act))
        else $error("Request does not outrank service");
    nest_block_a: assert property ($rose(O_CPU_REQ) && nest |-> act == 8'h00)
        else $error("Nested request while disabled");
endmodule : ips_props

bind ips_top ips_props #(.ADDR_W(ADDR_W)) u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR), .I_WDATA(I_WDATA),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_IRQ(O_IRQ),
    .O_CPU_REQ(O_CPU_REQ), .O_CPU_REQ_LVL(O_CPU_REQ_LVL), .I_CPU_ACK(I_CPU_ACK),
    .I_CPU_DONE(I_CPU_DONE)
);

//--- tb/testbench.sv
// Purpose: Self-checking bench for ips_top
// Assumes: AXI4-Lite master here, CPU model beside
// Notes:   Monitor pops expected reads and winners
`timescale 1ns/1ns
`include "ips_regs.svh"
module testbench;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        awv = 1'h0;
    logic        wv = 1'h0;
    logic        arv = 1'h0;
    logic [7:0]  awa = 8'h00;
    logic [7:0]  ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [2:0]  ev = 3'h0;
    logic [1:0]  dly = 2'h0;
    logic        ack, done, awrdy, wrdy, bvalid, arrdy, rvalid, irq, req;
    logic [1:0]  bresp, req_id, rresp;
    logic [2:0]  req_lvl;
    logic [31:0] rdata;
    logic [31:0] rd_q[$];
    logic [1:0]  id_q[$];
    int          mismatches = 0;
    int          total_checks = 0;
    int          acks = 0;
    always #20 clk = ~clk;
    ips_top u_ips_top (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awrdy),
        .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd),
        .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(1'h1), .O_BRESP(bresp),
        .I_ARVALID(arv), .O_ARREADY(arrdy), .I_ARADDR(ara), .O_RVALID(rvalid),
        .I_RREADY(1'h1), .O_RDATA(rdata), .O_RRESP(rresp), .I_SRC_EVENT(ev),
        .I_CPU_ACK(ack), .I_CPU_DONE(done), .O_IRQ(irq), .O_CPU_REQ(req),
        .O_CPU_REQ_ID(req_id), .O_CPU_REQ_LVL(req_lvl));
    ips_cpu_model u_ips_cpu_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
        .i_delay(dly), .o_ack(ack), .o_done(done));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic ta;
        logic tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge clk);
        awv <= 1'h1;
        wv  <= 1'h1;
        awa <= a;
        wd  <= d;
        while (!(ta && tw)) begin
            @(posedge clk);
            ta = ta | (awv & awrdy);
            tw = tw | (wv & wrdy);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end
        do @(posedge clk); while (bvalid !== 1'h1);
        chk("write resp", 32'(bresp), 32'(resp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        arv <= 1'h1;
        ara <= a;
        rd_q.push_back(e);
        do @(posedge clk); while (arrdy !== 1'h1);
        arv <= 1'h0;
        do @(posedge clk); while (rvalid !== 1'h1);
        chk("read resp", 32'(rresp), (a > 8'h10) ? 32'(`IPS_RESP_SLVERR) : 32'h0000_0000);
    endtask : rd
    task automatic pulse(input logic [2:0] b);
        @(posedge clk);
        ev <= b;
        @(posedge clk);
        ev <= 3'h0;
    endtask : pulse
    task automatic take(output logic [1:0] id);
        do @(posedge clk); while (!(ack && req));
        id = req_id;
    endtask : take
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rvalid) chk("read data", rdata, rd_q.pop_front());
        if (ack && req) begin
            acks++;
            chk("winner", 32'(req_id), 32'(id_q.pop_front()));
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        logic [2:0]  lv [3];
        logic [1:0]  id;
        logic [31:0] pv;
        int          base;
        void'($urandom(32'heb10_c700));
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        rd(`IPS_OFF_PRIO, 32'h0000_4404);
        wr(8'h14, 32'hFFFF_FFFF, `IPS_RESP_SLVERR);
        rd(8'h14, 32'h0000_0000);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            dly <= 2'($urandom_range(0, 3));
            for (int i = 0; i < 3; i++) lv[i] = (k == 0) ? 3'h5 : 3'($urandom_range(1, 7));
            if (k == 1) lv[1] = 3'h0;
            pv = {17'h0_0000, lv[0], 1'h0, lv[1], 5'h00, lv[2]};
            wr(`IPS_OFF_PRIO, pv | ($urandom() & 32'hFFFF_8888), `IPS_RESP_OKAY);
            rd(`IPS_OFF_PRIO, pv);
            pulse(3'h7);
            repeat (2) @(posedge clk);
            chk("masked irq", 32'(irq), 32'h0000_0000);
            rd(`IPS_OFF_FLAGS, 32'h0000_0007);
            wr(`IPS_OFF_FLAGS, 32'h0000_0007, `IPS_RESP_OKAY);
            wr(`IPS_OFF_ENABLES, 32'h0000_0007, `IPS_RESP_OKAY);
            repeat (2) @(posedge clk);
            chk("stale irq", 32'(irq), 32'h0000_0000);
            base = 0;
            for (int l = 7; l > 0; l--) begin
                for (int i = 0; i < 3; i++) begin
                    if (lv[i] == l) id_q.push_back(2'(i));
                    if (lv[i] == l) base++;
                end
            end
            pulse(3'h7);
            // Flag must go before service ends, or the source re-enters
            repeat (base) begin
                take(id);
                chk("winner level", 32'(req_lvl), 32'(lv[id]));
                wr(`IPS_OFF_FLAGS, 32'h0000_0001 << id, `IPS_RESP_OKAY);
            end
            repeat (60) @(posedge clk);
            wr(`IPS_OFF_ENABLES, 32'h0000_0000, `IPS_RESP_OKAY);
            wr(`IPS_OFF_FLAGS, 32'h0000_0007, `IPS_RESP_OKAY);
            $display("test arbitration %0d done", k);
        end
        for (int nst = 0; nst < 2; nst++) begin
            wr(`IPS_OFF_CTRL_ONE, 32'(nst) << 15, `IPS_RESP_OKAY);
            wr(`IPS_OFF_PRIO, 32'h0000_2006, `IPS_RESP_OKAY);
            wr(`IPS_OFF_ENABLES, 32'h0000_0005, `IPS_RESP_OKAY);
            id_q.push_back(2'h0);
            if (nst == 0) id_q.push_back(2'h2);
            base = acks;
            pulse(3'h1);
            take(id);
            wr(`IPS_OFF_FLAGS, 32'h0000_0001, `IPS_RESP_OKAY);
            pulse(3'h4);
            repeat (12) @(posedge clk);
            chk("nested acks", 32'(acks - base), 32'(2 - nst));
            wr(`IPS_OFF_FLAGS, 32'h0000_0004, `IPS_RESP_OKAY);
            repeat (100) @(posedge clk);
            $display("test nesting %0d done", nst);
        end
        conclude();
    end
endmodule : testbench

//--- verilog/ips_arbiter.sv
// Purpose: Pick the highest-level pending source
// Assumes: Level zero never wins; caller masks disabled sources
// Notes:   Equal levels resolve to the lowest index
`timescale 1ns/1ns
module ips_arbiter #(
    parameter int N_SRC = 3,
    parameter int LVL_W = 3
) (
    input  wire logic [N_SRC-1:0]            i_pend,
    input  wire logic [N_SRC-1:0][LVL_W-1:0] i_lvl,
    output logic                             o_valid,
    output logic [1:0]                       o_id,
    output logic [LVL_W-1:0]                 o_lvl
);
    if (N_SRC < 1 || N_SRC > 4) begin : g_chk
        $error("ips_arbiter: N_SRC must be 1 to 4");
    end

    always_comb begin
        o_valid = 1'b0;
        o_id    = 2'h0;
        o_lvl   = '0;
        for (int i = 0; i < N_SRC; i++) begin
            // Strict compare keeps the earlier source on a tie
            if (i_pend[i] && i_lvl[i] != '0 && i_lvl[i] > o_lvl) begin // RQ2 RQ3
                o_valid = 1'b1;
                o_id    = 2'(i);
                o_lvl   = i_lvl[i];
            end
        end
    end
endmodule : ips_arbiter

//--- verilog/ips_pkg.sv
// Purpose: Types shared by the priority block
// Assumes: Three sources, three-bit levels
// Notes:   Constants live in ips_regs.svh
package ips_pkg;

    typedef logic [2:0] ips_lvl_t;

    typedef struct packed {
        ips_lvl_t [2:0] prio;
        logic           nest_dis;
        logic [2:0]     flags;
        logic [2:0]     enab;
        logic [7:0]     active;
        logic           aw_held;
        logic [7:0]     aw_addr;
        logic           w_held;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           awrdy;
        logic           wrdy;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arrdy;
        logic           rvalid;
        logic [1:0]     rresp;
        logic [31:0]    rdata;
        logic           irq;
        logic           req;
        logic [1:0]     req_id;
        ips_lvl_t       req_lvl;
    } ips_state_s;

endpackage : ips_pkg

//--- verilog/ips_regs.svh
// Purpose: Register offsets, field positions and reset values of the priority block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   Definitions only
`ifndef IPS_REGS_SVH
`define IPS_REGS_SVH

`define IPS_OFF_PRIO        8'h00
`define IPS_OFF_CTRL_ONE    8'h04
`define IPS_OFF_FLAGS       8'h08
`define IPS_OFF_ENABLES     8'h0C
`define IPS_OFF_SERVICE     8'h10

// Priority field positions (low bit of each three-bit field)
`define IPS_POS_TIMER_SIX   12
`define IPS_POS_DMA_FOUR    8
`define IPS_POS_COMPARE_8   0

`define IPS_POS_NEST_DIS    15

`define IPS_PRIO_RESET      3'h4
`define IPS_PRIO_REG_RESET  16'h4404
`define IPS_PRIO_REG_MASK   16'h7707

`define IPS_RESP_OKAY       2'h0
`define IPS_RESP_SLVERR     2'h2

`endif

//--- verilog/ips_top.sv
// Purpose: Priority setup and arbitration for three interrupt sources
// Assumes: Source events and CPU handshakes are on I_CORE_CLK
// Notes:   AXI4-Lite slave, one write and one read at a time
//
// Overview of operation
// RQ1 - With nesting disable set, no new request is raised while any level is in service.
// RQ2 - Each source takes its level from its priority field and arbitration uses those levels.
// RQ3 - Sources may share one non-zero level; ties go to the lowest source index.
// RQ4 - Reset loads every priority field with level four.
// RQ5 - Software clears a source's pending flag before enabling it.
// RQ6 - A source only requests service once its enable bit is set.
// RQ7 - Fields are three bits, zero disables a source, unimplemented bits read zero.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "ips_regs.svh"
module ips_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [ADDR_W-1:0] I_AWADDR,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    output logic [1:0]             O_BRESP,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    input  wire logic [ADDR_W-1:0] I_ARADDR,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    input  wire logic [2:0]        I_SRC_EVENT,
    input  wire logic              I_CPU_ACK,
    input  wire logic              I_CPU_DONE,
    output logic                   O_IRQ,
    output logic                   O_CPU_REQ,
    output logic [1:0]             O_CPU_REQ_ID,
    output logic [2:0]             O_CPU_REQ_LVL
);
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
        $error("ips_top: ADDR_W must be 5 to 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset image

    localparam ips_pkg::ips_state_s RST_ST = '{
        prio:    {`IPS_PRIO_RESET, `IPS_PRIO_RESET, `IPS_PRIO_RESET},
        nest_dis: 1'b0,
        flags:   3'h0,
        enab:    3'h0,
        active:  8'h00,
        aw_held: 1'b0,
        aw_addr: 8'h00,
        w_held:  1'b0,
        w_data:  32'h0000_0000,
        w_strb:  4'h0,
        awrdy:   1'b1,
        wrdy:    1'b1,
        bvalid:  1'b0,
        bresp:   `IPS_RESP_OKAY,
        arrdy:   1'b1,
        rvalid:  1'b0,
        rresp:   `IPS_RESP_OKAY,
        rdata:   32'h0000_0000,
        irq:     1'b0,
        req:     1'b0,
        req_id:  2'h0,
        req_lvl: 3'h0
    };

    ips_pkg::ips_state_s st;
    ips_pkg::ips_state_s next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration among enabled, flagged sources

    logic [2:0]        pend;
    logic              win_valid;
    logic [1:0]        win_id;
    ips_pkg::ips_lvl_t win_lvl;

    assign pend = st.flags & st.enab; // RQ6

    ips_arbiter #(
        .N_SRC (3),
        .LVL_W (3)
    ) u_arb (
        .i_pend  (pend),
        .i_lvl   (st.prio),
        .o_valid (win_valid),
        .o_id    (win_id),
        .o_lvl   (win_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] r;
        r = old_v;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    function automatic logic [15:0] prio_word(input ips_pkg::ips_state_s s);
        logic [15:0] r;
        r = 16'h0000; // RQ7
        r[`IPS_POS_TIMER_SIX +: 3] = s.prio[0];
        r[`IPS_POS_DMA_FOUR  +: 3] = s.prio[1];
        r[`IPS_POS_COMPARE_8 +: 3] = s.prio[2];
        return r;
    endfunction : prio_word

    function automatic logic [2:0] top_level(input logic [7:0] act);
        logic [2:0] r;
        r = 3'h0;
        for (int l = 1; l < 8; l++) begin
            if (act[l]) begin
                r = 3'(l);
            end
        end
        return r;
    endfunction : top_level

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic        do_wr;
        logic [7:0]  wa;
        logic [7:0]  ra;
        logic [15:0] pw;
        logic [15:0] cw;
        logic [2:0]  clr;
        logic [2:0]  cur;
        logic        may_req;
        do_wr   = 1'b0;
        wa      = 8'h00;
        ra      = 8'h00;
        pw      = 16'h0000;
        cw      = 16'h0000;
        clr     = 3'h0;
        cur     = 3'h0;
        may_req = 1'b0;
        next_st = st;

        // Address and data may arrive in either order
        if (I_AWVALID && st.awrdy) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = 8'(I_AWADDR);
        end
        if (I_WVALID && st.wrdy) begin
            next_st.w_held = 1'b1;
            next_st.w_data = I_WDATA;
            next_st.w_strb = I_WSTRB;
        end
        if (st.bvalid && I_BREADY) begin
            next_st.bvalid = 1'b0;
        end

        do_wr = st.aw_held && st.w_held && !st.bvalid;
        if (do_wr) begin
            wa = {st.aw_addr[7:2], 2'b00};
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = `IPS_RESP_OKAY;
            unique case (wa)
                `IPS_OFF_PRIO: begin
                    pw = merge16(prio_word(st), st.w_data, st.w_strb);
                    next_st.prio[0] = pw[`IPS_POS_TIMER_SIX +: 3]; // RQ2
                    next_st.prio[1] = pw[`IPS_POS_DMA_FOUR  +: 3];
                    next_st.prio[2] = pw[`IPS_POS_COMPARE_8 +: 3];
                end
                `IPS_OFF_CTRL_ONE: begin
                    cw = merge16({st.nest_dis, 15'h0000}, st.w_data, st.w_strb);
                    next_st.nest_dis = cw[`IPS_POS_NEST_DIS]; // RQ1
                end
                `IPS_OFF_FLAGS: begin
                    if (st.w_strb[0]) begin
                        clr = st.w_data[2:0]; // RQ5
                    end
                end
                `IPS_OFF_ENABLES: begin
                    if (st.w_strb[0]) begin
                        next_st.enab = st.w_data[2:0]; // RQ6
                    end
                end
                `IPS_OFF_SERVICE: begin
                end
                default: begin
                    next_st.bresp = `IPS_RESP_SLVERR;
                end
            endcase
        end
        // Write-one-to-clear; a new event in the same cycle survives
        next_st.flags = (st.flags & ~clr) | I_SRC_EVENT;

        next_st.awrdy = !next_st.aw_held && !next_st.bvalid;
        next_st.wrdy  = !next_st.w_held && !next_st.bvalid;

        // Read channel
        if (st.rvalid && I_RREADY) begin
            next_st.rvalid = 1'b0;
            next_st.arrdy  = 1'b1;
        end
        if (I_ARVALID && st.arrdy) begin
            ra = {8'(I_ARADDR) & 8'hFC};
            next_st.arrdy  = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp  = `IPS_RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            unique case (ra)
                `IPS_OFF_PRIO:     next_st.rdata[15:0] = prio_word(st); // RQ7
                `IPS_OFF_CTRL_ONE: next_st.rdata[`IPS_POS_NEST_DIS] = st.nest_dis;
                `IPS_OFF_FLAGS:    next_st.rdata[2:0] = st.flags;
                `IPS_OFF_ENABLES:  next_st.rdata[2:0] = st.enab;
                `IPS_OFF_SERVICE:  next_st.rdata[10:0] = {top_level(st.active), st.active};
                default:           next_st.rresp = `IPS_RESP_SLVERR;
            endcase
        end

        // Service tracking: one active bit per level in service
        if (I_CPU_DONE) begin
            next_st.active[top_level(st.active)] = 1'b0;
        end
        if (I_CPU_ACK && st.req) begin
            next_st.active[st.req_lvl] = 1'b1;
        end
        cur = top_level(next_st.active);

        // Only a strictly higher level preempts, so equal levels never nest
        if (st.nest_dis) begin
            may_req = (next_st.active == 8'h00); // RQ1
        end else begin
            may_req = (win_lvl > cur); // RQ2 RQ3
        end
        next_st.req     = win_valid && may_req && !(I_CPU_ACK && st.req);
        next_st.req_id  = win_id;
        next_st.req_lvl = win_lvl;
        next_st.irq     = |(next_st.flags & next_st.enab);
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            st <= RST_ST; // RQ4
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign O_AWREADY     = st.awrdy;
    assign O_WREADY      = st.wrdy;
    assign O_BVALID      = st.bvalid;
    assign O_BRESP       = st.bresp;
    assign O_ARREADY     = st.arrdy;
    assign O_RVALID      = st.rvalid;
    assign O_RDATA       = st.rdata;
    assign O_RRESP       = st.rresp;
    assign O_IRQ         = st.irq;
    assign O_CPU_REQ     = st.req;
    assign O_CPU_REQ_ID  = st.req_id;
    assign O_CPU_REQ_LVL = st.req_lvl;

endmodule : ips_top
